// [wdu_top.v]
// Watchdog unit with timed unlock, register file and time-out logic
`timescale 1ns/1ps
`default_nettype none
`include "wdu_regs.vh"
// How it works
// - Counter advances on 128 kHz oscillator ticks, not system clock.
// - Restart instruction zeroes counter; missing it lets time-out action happen.
// - Fuse unprogrammed: reset/irq enables pick stopped, irq, reset or combined.
// - Fuse programmed forces reset enable one, irq enable zero.
// - Unlock bit clears itself four clock cycles after being set.
// - Clearing reset enable or changing period only accepted while unlocked.
// - Watchdog reset cause flag forces reset enable to one.
// - Time-out with interrupt configured sets the interrupt flag.
// - Vector execution clears the interrupt flag.
// - Writing one clears the interrupt flag; zero leaves it.
// - Request raised when flag, irq enable and global enable all set.
// - Combined mode vector clears irq enable and flag, leaving reset mode.
// - Combined mode time-out with flag still pending applies reset.
// - Period select bits 5,2..0 pick 2048 shl n oscillator cycles; codes above 9 give 2048 shl 9.
// - Time-out interrupt request wakes the device from sleep.
// - Control bits, reset enable included, reset to zero; a programmed fuse then sets reset enable.
// - Reset-mode time-out gives a one system clock reset pulse.
// - Reset cause flag set by watchdog reset, cleared by power-on or zero write.
module wdu_top #(
   parameter OSC_DIV     = `WDU_OSC_DIV,
   parameter UNLOCK_CYC  = `WDU_UNLOCK_CYCLES
) (
   // Clock and reset
   input  wire        ref_clk_in,
   input  wire        rstn_in,
   // Core side
   input  wire        restart_in,
   input  wire        vector_ack_in,
   input  wire        global_irq_en_in,
   input  wire        always_on_fuse_in,
   output wire        irq_out,
   output wire        wake_out,
   output reg         sys_reset_out,
   // AXI4-Lite write
   input  wire [3:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   output wire [1:0]  s_axi_bresp,
   output wire        s_axi_bvalid,
   input  wire        s_axi_bready,
   // AXI4-Lite read
   input  wire [3:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   output wire [31:0] s_axi_rdata,
   output wire [1:0]  s_axi_rresp,
   output wire        s_axi_rvalid,
   input  wire        s_axi_rready
);
   wire        tick;
   wire        wr_en;
   wire [3:0]  wr_addr;
   wire [7:0]  wr_data;
   wire [3:0]  rd_addr;
   reg  [7:0]  rd_data;
   reg  [7:0]  ctrl_reg;
   reg  [7:0]  ctrl_next;
   reg         cause_reg;
   reg         cause_next;
   reg  [2:0]  unlock_cnt_reg;
   reg  [2:0]  unlock_cnt_next;
   reg  [20:0] cnt_reg;
   reg  [20:0] cnt_next;
   reg  [3:0]  psel;
   reg         fuse_prog;
   reg         rst_en;
   reg         irq_en;
   reg  [1:0]  mode;
   reg         timeout;
   reg         to_irq;
   reg         to_rst;

   // Effective mode codes, reset enable in the upper bit
   localparam MODE_STOP = 2'b00;
   localparam MODE_IRQ  = 2'b01;
   localparam MODE_RST  = 2'b10;
   localparam MODE_BOTH = 2'b11;

   // Period length in oscillator cycles for a select code
   function [20:0] period_len;
      input [3:0] sel;
      begin
         if (sel > `WDU_PSEL_MAX)
            period_len = 21'd`WDU_BASE_PERIOD << `WDU_PSEL_MAX;
         else
            period_len = 21'd`WDU_BASE_PERIOD << sel;
      end
   endfunction

   // Address decode shared by read and write paths
   function addr_hit;
      input [3:0] a;
      begin
         addr_hit = (a == `WDU_OFS_CONTROL) || (a == `WDU_OFS_CAUSE);
      end
   endfunction

   wdu_osc_div #(
      .DIV (OSC_DIV)
   ) u_osc (
      .ref_clk_in (ref_clk_in),
      .rstn_in    (rstn_in),
      .tick_out   (tick)
   );

   wdu_axil u_bus (
      .ref_clk_in    (ref_clk_in),
      .rstn_in       (rstn_in),
      .s_axi_awaddr  (s_axi_awaddr),
      .s_axi_awvalid (s_axi_awvalid),
      .s_axi_awready (s_axi_awready),
      .s_axi_wdata   (s_axi_wdata),
      .s_axi_wstrb   (s_axi_wstrb),
      .s_axi_wvalid  (s_axi_wvalid),
      .s_axi_wready  (s_axi_wready),
      .s_axi_bresp   (s_axi_bresp),
      .s_axi_bvalid  (s_axi_bvalid),
      .s_axi_bready  (s_axi_bready),
      .s_axi_araddr  (s_axi_araddr),
      .s_axi_arvalid (s_axi_arvalid),
      .s_axi_arready (s_axi_arready),
      .s_axi_rdata   (s_axi_rdata),
      .s_axi_rresp   (s_axi_rresp),
      .s_axi_rvalid  (s_axi_rvalid),
      .s_axi_rready  (s_axi_rready),
      .wr_en_out     (wr_en),
      .wr_addr_out   (wr_addr),
      .wr_data_out   (wr_data),
      .wr_hit_in     (addr_hit(wr_addr)),
      .rd_addr_out   (rd_addr),
      .rd_data_in    (rd_data),
      .rd_hit_in     (addr_hit(rd_addr))
   );

   always @* begin
      if (rd_addr == `WDU_OFS_CONTROL)
         rd_data = ctrl_reg;
      else if (rd_addr == `WDU_OFS_CAUSE)
         rd_data = {4'h0, cause_reg, 3'b000};
      else
         rd_data = 8'h00;
   end

   // Mode decode and time-out detection
   always @* begin
      fuse_prog = !always_on_fuse_in;
      psel      = {ctrl_reg[`WDU_BIT_PSEL3], ctrl_reg[2:0]};
      rst_en    = fuse_prog | ctrl_reg[`WDU_BIT_RST_EN];
      irq_en    = !fuse_prog & ctrl_reg[`WDU_BIT_IRQ_EN];
      mode      = {rst_en, irq_en};
      // compare against selected period; >= catches a shortened period
      timeout   = tick && (mode != MODE_STOP) && (cnt_reg + 21'd1 >= period_len(psel));
      // Defaults keep the decode free of latches
      to_irq    = 1'b0;
      to_rst    = 1'b0;
      case (mode)
         MODE_STOP: begin
            to_irq = 1'b0;
            to_rst = 1'b0;
         end
         MODE_IRQ: begin
            to_irq = timeout;
         end
         MODE_RST: begin
            to_rst = timeout;
         end
         // pending flag in combined mode escalates
         MODE_BOTH: begin
            to_irq = timeout && !ctrl_reg[`WDU_BIT_IRQ_FLAG];
            to_rst = timeout && ctrl_reg[`WDU_BIT_IRQ_FLAG];
         end
         default: begin
            to_irq = 1'b0;
            to_rst = 1'b0;
         end
      endcase
   end

   // Control register next value
   always @* begin
      ctrl_next = ctrl_reg;
      if (wr_en && wr_addr == `WDU_OFS_CONTROL) begin
         ctrl_next[`WDU_BIT_IRQ_EN] = wr_data[`WDU_BIT_IRQ_EN];
         if (wr_data[`WDU_BIT_IRQ_FLAG])
            ctrl_next[`WDU_BIT_IRQ_FLAG] = 1'b0;
         if (ctrl_reg[`WDU_BIT_UNLOCK]) begin
            ctrl_next[`WDU_BIT_RST_EN] = wr_data[`WDU_BIT_RST_EN];
            ctrl_next[`WDU_BIT_PSEL3]  = wr_data[`WDU_BIT_PSEL3];
            ctrl_next[2:0]             = wr_data[2:0];
            ctrl_next[`WDU_BIT_UNLOCK] = 1'b0;
         end else begin
            ctrl_next[`WDU_BIT_RST_EN] = ctrl_reg[`WDU_BIT_RST_EN] | wr_data[`WDU_BIT_RST_EN];
         end
         // unlock needs both bits in one write
         if (wr_data[`WDU_BIT_UNLOCK] && wr_data[`WDU_BIT_RST_EN])
            ctrl_next[`WDU_BIT_UNLOCK] = 1'b1;
      end
      if (ctrl_reg[`WDU_BIT_UNLOCK] && unlock_cnt_reg == UNLOCK_CYC[2:0] - 3'd1)
         ctrl_next[`WDU_BIT_UNLOCK] = 1'b0;
      // combined mode drops irq enable too
      if (vector_ack_in) begin
         ctrl_next[`WDU_BIT_IRQ_FLAG] = 1'b0;
         if (rst_en)
            ctrl_next[`WDU_BIT_IRQ_EN] = 1'b0;
      end
      // Set wins over a clear in the same cycle
      if (to_irq)
         ctrl_next[`WDU_BIT_IRQ_FLAG] = 1'b1;
      // The control register alone is reset in the cycle that raises the pulse
      if (to_rst)
         ctrl_next = `WDU_CTRL_RESET;
      if (cause_reg || to_rst)
         ctrl_next[`WDU_BIT_RST_EN] = 1'b1;
      if (fuse_prog) begin
         ctrl_next[`WDU_BIT_RST_EN] = 1'b1;
         ctrl_next[`WDU_BIT_IRQ_EN] = 1'b0;
      end
   end

   // tick is a single-clock enable, so no crossing hazard remains
   // A stopped watchdog keeps its count at zero so enabling starts a full period
   always @* begin
      if (restart_in || timeout || mode == MODE_STOP)
         cnt_next = 21'd0;
      else if (tick)
         cnt_next = cnt_reg + 21'd1;
      else
         cnt_next = cnt_reg;
   end

   // window length in system clocks, restarted on every opening
   always @* begin
      if (ctrl_next[`WDU_BIT_UNLOCK] && !ctrl_reg[`WDU_BIT_UNLOCK])
         unlock_cnt_next = 3'd0;
      else if (ctrl_reg[`WDU_BIT_UNLOCK])
         unlock_cnt_next = unlock_cnt_reg + 3'd1;
      else
         unlock_cnt_next = unlock_cnt_reg;
   end

   // cause flag set on watchdog reset, zero write clears
   // The set wins so a reset cause is never lost to a racing write
   always @* begin
      if (to_rst)
         cause_next = 1'b1;
      else if (wr_en && wr_addr == `WDU_OFS_CAUSE && !wr_data[`WDU_BIT_WD_CAUSE])
         cause_next = 1'b0;
      else
         cause_next = cause_reg;
   end

   always @(posedge ref_clk_in) begin
      if (!rstn_in) begin
         ctrl_reg       <= `WDU_CTRL_RESET;
         cause_reg      <= 1'b0;
         unlock_cnt_reg <= 3'd0;
         cnt_reg        <= 21'd0;
         sys_reset_out  <= 1'b0;
      end else begin
         // All next values are formed above; this process only registers them
         ctrl_reg       <= ctrl_next;
         cause_reg      <= cause_next;
         unlock_cnt_reg <= unlock_cnt_next;
         cnt_reg        <= cnt_next;
         sys_reset_out  <= to_rst;
      end
   end

   // request gated by flag and both enables
   assign irq_out  = ctrl_reg[`WDU_BIT_IRQ_FLAG] & ctrl_reg[`WDU_BIT_IRQ_EN] & global_irq_en_in;
   // wake ignores the global enable so sleep can end
   assign wake_out = ctrl_reg[`WDU_BIT_IRQ_FLAG] & ctrl_reg[`WDU_BIT_IRQ_EN];
endmodule // wdu_top
`default_nettype wire

// [wdu_regs.vh]
// Register map, field positions and timing constants of the watchdog unit
`ifndef WDU_REGS_VH
`define WDU_REGS_VH

// Byte offsets on the register bus
`define WDU_OFS_CONTROL     4'h0
`define WDU_OFS_CAUSE       4'h4

// watchdog_control fields
`define WDU_BIT_IRQ_FLAG    7
`define WDU_BIT_IRQ_EN      6
`define WDU_BIT_PSEL3       5
`define WDU_BIT_UNLOCK      4
`define WDU_BIT_RST_EN      3
`define WDU_CTRL_RESET      8'h00

// reset_cause_status fields
`define WDU_BIT_WD_CAUSE    3

// Timing
`define WDU_SYS_CLK_HZ      25000000
`define WDU_OSC_HZ          128000
`define WDU_OSC_DIV         (`WDU_SYS_CLK_HZ / `WDU_OSC_HZ)
`define WDU_UNLOCK_CYCLES   4
`define WDU_BASE_PERIOD     2048
`define WDU_PSEL_MAX        4'h9

`endif

// [wdu_osc_div.v]
// Divider that stands in for the 128 kHz watchdog oscillator as an enable pulse
`timescale 1ns/1ps
`default_nettype none
module wdu_osc_div #(
   parameter DIV = 195
) (
   // Clock and reset
   input  wire ref_clk_in,
   input  wire rstn_in,
   // Oscillator tick
   output reg  tick_out
);
   reg [7:0] cnt_reg;

   always @(posedge ref_clk_in) begin
      if (!rstn_in) begin
         cnt_reg  <= 8'h00;
         tick_out <= 1'b0;
      end else if (cnt_reg == DIV[7:0] - 8'h01) begin
         cnt_reg  <= 8'h00;
         tick_out <= 1'b1;
      end else begin
         cnt_reg  <= cnt_reg + 8'h01;
         tick_out <= 1'b0;
      end
   end
endmodule // wdu_osc_div
`default_nettype wire

// [wdu_axil.v]
// AXI4-Lite slave front end for the watchdog registers
`timescale 1ns/1ps
`default_nettype none
module wdu_axil (
   // Clock and reset
   input  wire        ref_clk_in,
   input  wire        rstn_in,
   // AXI4-Lite write
   input  wire [3:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   // AXI4-Lite read
   input  wire [3:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   // Register side
   output wire        wr_en_out,
   output wire [3:0]  wr_addr_out,
   output wire [7:0]  wr_data_out,
   input  wire        wr_hit_in,
   output wire [3:0]  rd_addr_out,
   input  wire [7:0]  rd_data_in,
   input  wire        rd_hit_in
);
   reg        aw_full_reg;
   reg        w_full_reg;
   reg [3:0]  awaddr_reg;
   reg [7:0]  wdata_reg;
   reg        wlane_reg;

   assign s_axi_awready = !aw_full_reg && !s_axi_bvalid;
   assign s_axi_wready  = !w_full_reg && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;
   // Only byte lane 0 carries register bits; a write without it stores nothing
   assign wr_en_out     = aw_full_reg && w_full_reg && wlane_reg;
   assign wr_addr_out   = awaddr_reg;
   assign wr_data_out   = wdata_reg;
   assign rd_addr_out   = s_axi_araddr;

   always @(posedge ref_clk_in) begin
      if (!rstn_in) begin
         aw_full_reg  <= 1'b0;
         w_full_reg   <= 1'b0;
         awaddr_reg   <= 4'h0;
         wdata_reg    <= 8'h00;
         wlane_reg    <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= 2'b00;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp  <= 2'b00;
         s_axi_rdata  <= 32'h0000_0000;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_full_reg <= 1'b1;
            awaddr_reg  <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_full_reg <= 1'b1;
            wdata_reg  <= s_axi_wdata[7:0];
            wlane_reg  <= s_axi_wstrb[0];
         end
         if (aw_full_reg && w_full_reg) begin
            aw_full_reg  <= 1'b0;
            w_full_reg   <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit_in ? 2'b00 : 2'b10;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= {24'h00_0000, rd_data_in};
            s_axi_rresp  <= rd_hit_in ? 2'b00 : 2'b10;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule // wdu_axil
`default_nettype wire

// [wdu_chk.sv]
// Port-level assertion checker for the watchdog unit
`timescale 1ns/1ps
`default_nettype none
module wdu_chk (
   // Clock and reset
   input wire logic        ref_clk_in,
   input wire logic        rstn_in,
   // Core side
   input wire logic        vector_ack_in,
   input wire logic        global_irq_en_in,
   input wire logic        always_on_fuse_in,
   input wire logic        irq_out,
   input wire logic        wake_out,
   input wire logic        sys_reset_out,
   // Register bus
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready
);
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!rstn_in);
   property p_irq_gate;
      irq_out == (wake_out && global_irq_en_in);
   endproperty
   a_irq_gate: assert property (p_irq_gate) else $error("irq not flag and enables");
   property p_rst_pulse;
      sys_reset_out |=> !sys_reset_out;
   endproperty
   a_rst_pulse: assert property (p_rst_pulse) else $error("reset pulse too long");
   property p_vec_clr;
      vector_ack_in |=> !wake_out;
   endproperty
   a_vec_clr: assert property (p_vec_clr) else $error("vector left request");
   property p_fuse;
      !always_on_fuse_in && !$past(always_on_fuse_in, 2) |-> !wake_out;
   endproperty
   a_fuse: assert property (p_fuse) else $error("irq with fuse programmed");
   property p_b_code;
      s_axi_bvalid |-> !s_axi_bresp[0];
   endproperty
   a_b_code: assert property (p_b_code) else $error("write response code not okay or error");
   property p_aw_block;
      s_axi_bvalid |-> !s_axi_awready;
   endproperty
   a_aw_block: assert property (p_aw_block) else $error("aw taken with response due");
   property p_ar_block;
      s_axi_rvalid |-> !s_axi_arready;
   endproperty
   a_ar_block: assert property (p_ar_block) else $error("ar taken with data due");
   property p_r_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_r_hold: assert property (p_r_hold) else $error("read data dropped");
   property p_r_lat;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
   endproperty
   a_r_lat: assert property (p_r_lat) else $error("read answer late");
   property p_b_lat;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid;
   endproperty
   a_b_lat: assert property (p_b_lat) else $error("write answer late");
   c_irq: cover property ($rose(irq_out));
   c_rst: cover property (sys_reset_out);
   c_vec: cover property (vector_ack_in && wake_out);
endmodule // wdu_chk
`default_nettype wire

// [wdu_tb.sv]
// Self-checking testbench for the watchdog unit
`timescale 1ns/1ps
`default_nettype none
module tb;
   localparam int DIV = 2;
   localparam int TO0 = 2048 * DIV;
   logic        ref_clk_in, rstn_in, restart_in, vector_ack_in;
   logic        global_irq_en_in, always_on_fuse_in;
   logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
   logic [31:0] s_axi_wdata;
   logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   wire         irq_out, wake_out, sys_reset_out, s_axi_awready, s_axi_wready;
   wire         s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire [1:0]   s_axi_bresp, s_axi_rresp;
   wire [31:0]  s_axi_rdata;
   int          bad_count, cmp_count;
   wdu_top #(.OSC_DIV(DIV), .UNLOCK_CYC(4)) DUT (.ref_clk_in, .rstn_in, .restart_in,
      .vector_ack_in, .global_irq_en_in, .always_on_fuse_in, .irq_out, .wake_out,
      .sys_reset_out, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk_in);
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic hang;
      bad_count++;
      wrap_up();
   endtask
   // Write one word; response code compared
   task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [1:0] er);
      int n;
      s_axi_awaddr  <= a;
      s_axi_wdata   <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge ref_clk_in);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid === 1'b1) break;
      end
      if (n == 50) hang();
      chk({30'h0, s_axi_bresp}, {30'h0, er});
   endtask
   // Read one word; rready raised late so read data must stand
   task automatic rd(input logic [3:0] a, input logic [7:0] e, input logic [1:0] er);
      int n;
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b0;
      for (n = 0; n < 50; n++) begin
         @(posedge ref_clk_in);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid === 1'b1 && s_axi_rready) break;
         if (s_axi_rvalid === 1'b1) s_axi_rready <= 1'b1;
      end
      if (n == 50) hang();
      chk(s_axi_rdata, {24'h0, e});
      chk({30'h0, s_axi_rresp}, {30'h0, er});
   endtask
   // Wait for wake (0) or system reset (1), cycles counted
   task automatic wait_hi(input int which, input int lim, output int n);
      for (n = 0; n < lim; n++) begin
         @(posedge ref_clk_in);
         if ((which == 1 ? sys_reset_out : wake_out) === 1'b1) break;
      end
      if (n == lim) hang();
   endtask
   task automatic kick;
      restart_in <= 1'b1;
      tick(1);
      restart_in <= 1'b0;
   endtask
   task automatic vec;
      vector_ack_in <= 1'b1;
      tick(1);
      vector_ack_in <= 1'b0;
   endtask
   initial begin
      ref_clk_in = 1'b0;
      forever #20 ref_clk_in = ~ref_clk_in;
   end
   initial begin : main
      int n;
      rstn_in = 1'b0;
      restart_in = 1'b0;
      vector_ack_in = 1'b0;
      global_irq_en_in = 1'b0;
      always_on_fuse_in = 1'b1;
      s_axi_awaddr = 4'h0;
      s_axi_araddr = 4'h0;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'hf;
      s_axi_awvalid = 1'b0;
      s_axi_wvalid = 1'b0;
      s_axi_bready = 1'b0;
      s_axi_arvalid = 1'b0;
      s_axi_rready = 1'b0;
      tick(12);
      rstn_in <= 1'b1;
      tick(1);
      rd(4'h0, 8'h00, 2'h0);
      rd(4'h4, 8'h00, 2'h0);
      rd(4'h8, 8'h00, 2'h2);
      wr(4'hc, 8'hff, 2'h2);
      $display("test reset values done");
      wr(4'h0, 8'h05, 2'h0);
      rd(4'h0, 8'h00, 2'h0);
      wr(4'h0, 8'h08, 2'h0);
      wr(4'h0, 8'h00, 2'h0);
      rd(4'h0, 8'h08, 2'h0);
      wr(4'h0, 8'h18, 2'h0);
      wr(4'h0, 8'h01, 2'h0);
      rd(4'h0, 8'h01, 2'h0);
      wr(4'h0, 8'h19, 2'h0);
      tick(8);
      wr(4'h0, 8'h00, 2'h0);
      rd(4'h0, 8'h09, 2'h0);
      $display("test unlock done");
      kick();
      wr(4'h0, 8'h19, 2'h0);
      wr(4'h0, 8'h40, 2'h0);
      repeat (3) begin
         tick(TO0 / 2);
         kick();
      end
      rd(4'h0, 8'h40, 2'h0);
      kick();
      wait_hi(0, 2 * TO0, n);
      chk(n >= TO0 - 8 && n <= TO0 + 8, 1);
      chk(irq_out, 1'b0);
      global_irq_en_in <= 1'b1;
      tick(1);
      chk(irq_out, 1'b1);
      rd(4'h0, 8'hc0, 2'h0);
      wr(4'h0, 8'h40, 2'h0);
      rd(4'h0, 8'hc0, 2'h0);
      wr(4'h0, 8'hc0, 2'h0);
      rd(4'h0, 8'h40, 2'h0);
      wait_hi(0, 2 * TO0, n);
      vec();
      rd(4'h0, 8'h40, 2'h0);
      global_irq_en_in <= 1'b0;
      $display("test interrupt mode done");
      wr(4'h0, 8'h48, 2'h0);
      kick();
      wait_hi(0, 2 * TO0, n);
      rd(4'h0, 8'hc8, 2'h0);
      vec();
      rd(4'h0, 8'h08, 2'h0);
      wr(4'h0, 8'h48, 2'h0);
      wait_hi(0, 2 * TO0, n);
      wait_hi(1, 2 * TO0, n);
      chk(n >= TO0 - 8 && n <= TO0 + 8, 1);
      tick(2);
      kick();
      rd(4'h0, 8'h08, 2'h0);
      rd(4'h4, 8'h08, 2'h0);
      wr(4'h0, 8'h18, 2'h0);
      wr(4'h0, 8'h00, 2'h0);
      rd(4'h0, 8'h08, 2'h0);
      wr(4'h4, 8'h00, 2'h0);
      rd(4'h4, 8'h00, 2'h0);
      wr(4'h0, 8'h18, 2'h0);
      wr(4'h0, 8'h00, 2'h0);
      rd(4'h0, 8'h00, 2'h0);
      $display("test combined mode done");
      always_on_fuse_in <= 1'b0;
      rstn_in <= 1'b0;
      tick(2);
      rstn_in <= 1'b1;
      tick(2);
      rd(4'h0, 8'h08, 2'h0);
      wr(4'h0, 8'h40, 2'h0);
      rd(4'h0, 8'h08, 2'h0);
      $display("test fuse done");
      wrap_up();
   end
endmodule // tb
bind wdu_top wdu_chk u_chk (.ref_clk_in, .rstn_in, .vector_ack_in, .global_irq_en_in,
   .always_on_fuse_in, .irq_out, .wake_out, .sys_reset_out, .s_axi_awvalid,
   .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready);
`default_nettype wire
